// ### hw/bdr_pkg.sv
/*
  constants, opcode patterns and types for the decimal adjust, decrement,
  rotate and return execution unit.
  assumes: an 8-bit core with 16-bit instruction words and a classic
  wishbone register port with 32-bit data.
*/
`default_nettype none
package bdr_pkg;
  // datapath widths
  localparam int ACC_W     = 8;
  localparam int FILE_AW   = 12;
  localparam int PC_W      = 21;
  localparam int BANK_W    = 4;
  localparam int STATUS_W  = 5;
  localparam int INSTR_W   = 16;
  localparam int WB_AW     = 8;
  localparam int WB_DW     = 32;
  localparam int STACK_DEP = 31;

  // register byte addresses
  localparam logic [7:0] ADR_CTRL      = 8'h00;
  localparam logic [7:0] ADR_ACC       = 8'h04;
  localparam logic [7:0] ADR_FLAGS     = 8'h08;
  localparam logic [7:0] ADR_BANK      = 8'h0C;
  localparam logic [7:0] ADR_SH_ACC    = 8'h10;
  localparam logic [7:0] ADR_SH_FLAGS  = 8'h14;
  localparam logic [7:0] ADR_SH_BANK   = 8'h18;
  localparam logic [7:0] ADR_IDX_BASE  = 8'h1C;
  localparam logic [7:0] ADR_PC        = 8'h20;
  localparam logic [7:0] ADR_PCL_UPPER = 8'h24;
  localparam logic [7:0] ADR_PCL_HIGH  = 8'h28;
  localparam logic [7:0] ADR_STACK     = 8'h2C;
  localparam logic [7:0] ADR_STATE     = 8'h30;

  // control and state register fields
  localparam int CTRL_EXT_BIT  = 0;
  localparam int STATE_BUSY    = 0;
  localparam int STATE_SP_LSB  = 8;

  // status flag positions
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_OV = 3;
  localparam int ST_N  = 4;

  // opcode patterns and fields
  localparam logic [15:0] OPC_DECADJ = 16'h0007;
  localparam logic [5:0]  OPC_DECREMENT_FILE   = 6'h01;
  localparam logic [5:0]  OPC_RLC    = 6'h0D;
  localparam logic [14:0] OPC_RET    = 15'h0009;
  localparam int OPC_D_BIT = 9;
  localparam int OPC_A_BIT = 8;
  localparam int OPC_S_BIT = 0;

  // arithmetic and addressing constants
  localparam logic [3:0]  NIB_MAX         = 4'h9;
  localparam logic [3:0]  NIB_ADJ         = 4'h6;
  localparam logic [7:0]  ONE_BYTE        = 8'h01;
  localparam logic [7:0]  SIGN_MIN        = 8'h80;
  localparam logic [7:0]  ILO_TOP         = 8'h5F;
  localparam logic [7:0]  ACCESS_LOW_TOP  = 8'h7F;
  localparam logic [3:0]  ACCESS_HIGH_BNK = 4'hF;

  typedef enum logic [1:0] {
    BDR_OP_NONE,
    BDR_OP_DECADJ,
    BDR_OP_DECREMENT_FILE,
    BDR_OP_RLC
  } bdr_op_e;

  typedef enum logic [2:0] {
    BDR_PH_IDLE,
    BDR_PH_Q1,
    BDR_PH_Q2,
    BDR_PH_Q3,
    BDR_PH_Q4
  } bdr_phase_e;
endpackage : bdr_pkg
`default_nettype wire

// ### hw/bdr_alu_if.sv
/*
  interface between the sequencer and the arithmetic unit.
  assumes: both ends in the core clock domain; the path is combinational.
*/
`default_nettype none
interface bdr_alu_if;
  bdr_pkg::bdr_op_e               op;
  logic [bdr_pkg::ACC_W-1:0]      operand;
  logic [bdr_pkg::STATUS_W-1:0]   flags_in;
  logic [bdr_pkg::ACC_W-1:0]      result;
  logic [bdr_pkg::STATUS_W-1:0]   flags_out;

  modport core (output op, operand, flags_in, input result, flags_out);
  modport alu  (input op, operand, flags_in, output result, flags_out);
endinterface : bdr_alu_if
`default_nettype wire

// ### hw/bdr_alu.sv
/*
  combinational arithmetic for decimal adjust, decrement and rotate left
  through carry; computes the result byte and the full next flag set.
  assumes: the sequencer registers the outputs before use.
*/
`default_nettype none
module bdr_alu (
  bdr_alu_if.alu a_if
);
  logic [8:0] lo_sum;
  logic       lo_fix;
  logic       hi_fix;
  logic [7:0] dec_res;

  // result and flags per operation
  always_comb begin
    a_if.result    = a_if.operand;
    a_if.flags_out = a_if.flags_in;
    lo_fix  = (a_if.operand[3:0] > bdr_pkg::NIB_MAX)
              || a_if.flags_in[bdr_pkg::ST_DC];
    lo_sum  = lo_fix ? {1'b0, a_if.operand} + {5'h00, bdr_pkg::NIB_ADJ}
                     : {1'b0, a_if.operand};
    hi_fix  = (lo_sum[7:4] > bdr_pkg::NIB_MAX) || lo_sum[8]
              || a_if.flags_in[bdr_pkg::ST_C];
    dec_res = a_if.operand - bdr_pkg::ONE_BYTE;
    unique case (a_if.op)
      bdr_pkg::BDR_OP_NONE: begin
      end
      bdr_pkg::BDR_OP_DECADJ: begin
        // upper nibble correction sets carry, other flags kept
        a_if.result[3:0] = lo_sum[3:0];
        a_if.result[7:4] = hi_fix ? lo_sum[7:4] + bdr_pkg::NIB_ADJ
                                  : lo_sum[7:4];
        if (hi_fix) begin
          a_if.flags_out[bdr_pkg::ST_C] = 1'b1;
        end
      end
      bdr_pkg::BDR_OP_DECREMENT_FILE: begin
        a_if.result = dec_res;
        a_if.flags_out[bdr_pkg::ST_C]  = (a_if.operand != 8'h00);
        a_if.flags_out[bdr_pkg::ST_DC] = (a_if.operand[3:0] != 4'h0);
        a_if.flags_out[bdr_pkg::ST_Z]  = (dec_res == 8'h00);
        a_if.flags_out[bdr_pkg::ST_N]  = dec_res[7];
        a_if.flags_out[bdr_pkg::ST_OV] = (a_if.operand == bdr_pkg::SIGN_MIN);
      end
      bdr_pkg::BDR_OP_RLC: begin
        a_if.result = {a_if.operand[6:0],
                       a_if.flags_in[bdr_pkg::ST_C]};
        a_if.flags_out[bdr_pkg::ST_C] = a_if.operand[7];
        a_if.flags_out[bdr_pkg::ST_Z] =
          ({a_if.operand[6:0], a_if.flags_in[bdr_pkg::ST_C]} == 8'h00);
        a_if.flags_out[bdr_pkg::ST_N] = a_if.operand[6];
      end
    endcase
  end
endmodule : bdr_alu
`default_nettype wire

// ### hw/bdr_exec_unit.sv
/*
  execution unit: decimal adjust, decrement of a file register, rotate
  left through carry and return with optional shadow restore. each
  instruction cycle is four clocks (q1..q4). registers over wishbone.
  assumes: the decoder holds instr_valid_i until instr_ready_o; the file
  register memory returns read data one clock after file_rd_o.
*/
`default_nettype none
// Summary of operation
// - decimal adjust adds 6 to lower nibble when correction applies.
// - decrement subtracts one; destination bit picks accumulator or file.
// - access bit 0 uses access bank, 1 uses bank select register.
// - access 0 with extended set uses indexed offset for f up to 95.
// - return decodes from pattern ending 001s; two cycles, second idle.
// - return pops stack into program counter during fourth quarter.
// - restore flag 1 copies shadow accumulator, flags, bank select back.
// - restore flag 0 leaves those untouched; return then changes no flag.
// - return leaves upper and high program counter latches unchanged.
// - rotate shifts bits up, bit 7 into carry, carry into bit 0.
// - rotate destination bit picks accumulator or file register.
module bdr_exec_unit #(
  parameter int STACK_DEPTH = bdr_pkg::STACK_DEP
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [bdr_pkg::WB_AW-1:0]     wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [bdr_pkg::WB_DW-1:0]     wb_dat_i,
  output logic      [bdr_pkg::WB_DW-1:0]     wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic                          instr_valid_i,
  input  wire logic [bdr_pkg::INSTR_W-1:0]   instr_i,
  output logic                               instr_ready_o,
  output logic                               instr_done_o,
  output logic      [bdr_pkg::FILE_AW-1:0]   file_addr_o,
  output logic                               file_rd_o,
  input  wire logic [bdr_pkg::ACC_W-1:0]     file_rdata_i,
  output logic                               file_we_o,
  output logic      [bdr_pkg::ACC_W-1:0]     file_wdata_o,
  output logic      [bdr_pkg::PC_W-1:0]      pc_o,
  output logic                               pc_load_o
);
  localparam int SP_W = $clog2(STACK_DEPTH + 1);

  bdr_alu_if alu_bus ();

  bdr_pkg::bdr_phase_e              phase_q, phase_d;
  logic                             idle_cyc_q, idle_cyc_d;
  logic [bdr_pkg::INSTR_W-1:0]      instr_q, instr_d;
  logic [bdr_pkg::ACC_W-1:0]        acc_q, acc_d, sh_acc_q, sh_acc_d;
  logic [bdr_pkg::STATUS_W-1:0]     flags_q, flags_d, sh_flags_q, sh_flags_d;
  logic [bdr_pkg::STATUS_W-1:0]     res_flags_q, res_flags_d;
  logic [bdr_pkg::BANK_W-1:0]       bank_q, bank_d, sh_bank_q, sh_bank_d;
  logic [bdr_pkg::FILE_AW-1:0]      idx_base_q, idx_base_d;
  logic [bdr_pkg::FILE_AW-1:0]      faddr_q, faddr_d;
  logic [bdr_pkg::PC_W-1:0]         pc_q, pc_d;
  logic [bdr_pkg::ACC_W-1:0]        pcl_up_q, pcl_up_d, pcl_hi_q, pcl_hi_d;
  logic [bdr_pkg::ACC_W-1:0]        wdata_q, wdata_d;
  logic                             ext_en_q, ext_en_d;
  logic [SP_W-1:0]                  sp_q, sp_d;
  logic [bdr_pkg::PC_W-1:0]         stack_mem [STACK_DEPTH];
  logic [bdr_pkg::PC_W-1:0]         stack_top;
  logic                             push_en;
  logic                             ack_q, ack_d;
  logic [bdr_pkg::WB_DW-1:0]        rdata_q, rdata_d;
  logic                             bus_req, bus_wr;
  logic [bdr_pkg::WB_DW-1:0]        rd_mux, wr_merged;
  bdr_pkg::bdr_op_e                 op_dec;
  logic                             is_ret, dest_file, acc_bit, restore;

  // merge a bus write into a register under byte enables
  function automatic logic [31:0] bdr_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return m;
  endfunction : bdr_merge

  // opcode decode of the held instruction
  always_comb begin
    op_dec    = bdr_pkg::BDR_OP_NONE;
    is_ret    = (instr_q[15:1] == bdr_pkg::OPC_RET);
    restore   = instr_q[bdr_pkg::OPC_S_BIT];
    dest_file = instr_q[bdr_pkg::OPC_D_BIT];
    acc_bit   = instr_q[bdr_pkg::OPC_A_BIT];
    if (instr_q == bdr_pkg::OPC_DECADJ) begin
      op_dec = bdr_pkg::BDR_OP_DECADJ;
    end else if (instr_q[15:10] == bdr_pkg::OPC_DECREMENT_FILE) begin
      op_dec = bdr_pkg::BDR_OP_DECREMENT_FILE;
    end else if (instr_q[15:10] == bdr_pkg::OPC_RLC) begin
      op_dec = bdr_pkg::BDR_OP_RLC;
    end
  end

  // arithmetic unit, operand is accumulator or fresh file read data
  assign alu_bus.op       = op_dec;
  assign alu_bus.operand  = (op_dec == bdr_pkg::BDR_OP_DECADJ) ? acc_q
                                                               : file_rdata_i;
  assign alu_bus.flags_in = flags_q;

  bdr_alu u_alu (
    .a_if (alu_bus.alu)
  );

  // stack top view; empty stack reads zero
  assign stack_top = (sp_q == '0) ? '0 : stack_mem[sp_q - SP_W'(1)];

  // wishbone request decode and read mux
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_wr  = bus_req && wb_we_i && ack_q;
  assign push_en = bus_wr && (wb_adr_i == bdr_pkg::ADR_STACK)
                   && (32'(sp_q) < STACK_DEPTH) && wb_sel_i[0];
  always_comb begin
    rd_mux = '0;
    unique case (wb_adr_i)
      bdr_pkg::ADR_CTRL:      rd_mux[bdr_pkg::CTRL_EXT_BIT] = ext_en_q;
      bdr_pkg::ADR_ACC:       rd_mux[7:0] = acc_q;
      bdr_pkg::ADR_FLAGS:     rd_mux[bdr_pkg::STATUS_W-1:0] = flags_q;
      bdr_pkg::ADR_BANK:      rd_mux[bdr_pkg::BANK_W-1:0] = bank_q;
      bdr_pkg::ADR_SH_ACC:    rd_mux[7:0] = sh_acc_q;
      bdr_pkg::ADR_SH_FLAGS:  rd_mux[bdr_pkg::STATUS_W-1:0] = sh_flags_q;
      bdr_pkg::ADR_SH_BANK:   rd_mux[bdr_pkg::BANK_W-1:0] = sh_bank_q;
      bdr_pkg::ADR_IDX_BASE:  rd_mux[bdr_pkg::FILE_AW-1:0] = idx_base_q;
      bdr_pkg::ADR_PC:        rd_mux[bdr_pkg::PC_W-1:0] = pc_q;
      bdr_pkg::ADR_PCL_UPPER: rd_mux[7:0] = pcl_up_q;
      bdr_pkg::ADR_PCL_HIGH:  rd_mux[7:0] = pcl_hi_q;
      bdr_pkg::ADR_STACK:     rd_mux[bdr_pkg::PC_W-1:0] = stack_top;
      bdr_pkg::ADR_STATE: begin
        rd_mux[bdr_pkg::STATE_BUSY] = (phase_q != bdr_pkg::BDR_PH_IDLE);
        rd_mux[bdr_pkg::STATE_SP_LSB +: SP_W] = sp_q;
      end
      default:                rd_mux = '0;
    endcase
  end

  // bus write data merged into the addressed register's current value
  assign wr_merged = bdr_merge(rd_mux, wb_dat_i, wb_sel_i);

  // bus handshake: ack one clock after the request, data registered
  always_comb begin
    ack_d   = bus_req && !ack_q;
    rdata_d = ack_d ? rd_mux : rdata_q;
  end

  // file address generation for the held instruction
  always_comb begin
    faddr_d = faddr_q;
    if (phase_q == bdr_pkg::BDR_PH_Q1) begin
      if (acc_bit) begin
        faddr_d = {bank_q, instr_q[7:0]};
      end else if (ext_en_q && instr_q[7:0] <= bdr_pkg::ILO_TOP) begin
        faddr_d = idx_base_q + {4'h0, instr_q[7:0]};
      end else if (instr_q[7:0] <= bdr_pkg::ACCESS_LOW_TOP) begin
        faddr_d = {4'h0, instr_q[7:0]};
      end else begin
        faddr_d = {bdr_pkg::ACCESS_HIGH_BNK, instr_q[7:0]};
      end
    end
  end

  // sequencer and architectural state next values
  always_comb begin
    phase_d     = phase_q;
    idle_cyc_d  = idle_cyc_q;
    instr_d     = instr_q;
    acc_d       = acc_q;
    flags_d     = flags_q;
    bank_d      = bank_q;
    sh_acc_d    = sh_acc_q;
    sh_flags_d  = sh_flags_q;
    sh_bank_d   = sh_bank_q;
    idx_base_d  = idx_base_q;
    pc_d        = pc_q;
    pcl_up_d    = pcl_up_q;
    pcl_hi_d    = pcl_hi_q;
    ext_en_d    = ext_en_q;
    wdata_d     = wdata_q;
    res_flags_d = res_flags_q;
    sp_d        = push_en ? sp_q + SP_W'(1) : sp_q;
    // software writes, taken at the edge where ack is high
    if (bus_wr) begin
      unique case (wb_adr_i)
        bdr_pkg::ADR_CTRL:
          ext_en_d = wr_merged[bdr_pkg::CTRL_EXT_BIT];
        bdr_pkg::ADR_ACC:
          acc_d = wr_merged[bdr_pkg::ACC_W-1:0];
        bdr_pkg::ADR_FLAGS:
          flags_d = wr_merged[bdr_pkg::STATUS_W-1:0];
        bdr_pkg::ADR_BANK:
          bank_d = wr_merged[bdr_pkg::BANK_W-1:0];
        bdr_pkg::ADR_SH_ACC:
          sh_acc_d = wr_merged[bdr_pkg::ACC_W-1:0];
        bdr_pkg::ADR_SH_FLAGS:
          sh_flags_d = wr_merged[bdr_pkg::STATUS_W-1:0];
        bdr_pkg::ADR_SH_BANK:
          sh_bank_d = wr_merged[bdr_pkg::BANK_W-1:0];
        bdr_pkg::ADR_IDX_BASE:
          idx_base_d = wr_merged[bdr_pkg::FILE_AW-1:0];
        bdr_pkg::ADR_PC:
          pc_d = wr_merged[bdr_pkg::PC_W-1:0];
        bdr_pkg::ADR_PCL_UPPER:
          pcl_up_d = wr_merged[bdr_pkg::ACC_W-1:0];
        bdr_pkg::ADR_PCL_HIGH:
          pcl_hi_d = wr_merged[bdr_pkg::ACC_W-1:0];
        default: begin
        end
      endcase
    end
    // instruction sequence; its writes win over same-cycle bus writes
    unique case (phase_q)
      bdr_pkg::BDR_PH_IDLE: begin
        if (instr_valid_i) begin
          instr_d    = instr_i;
          idle_cyc_d = 1'b0;
          phase_d    = bdr_pkg::BDR_PH_Q1;
        end
      end
      bdr_pkg::BDR_PH_Q1: phase_d = bdr_pkg::BDR_PH_Q2;
      bdr_pkg::BDR_PH_Q2: phase_d = bdr_pkg::BDR_PH_Q3;
      bdr_pkg::BDR_PH_Q3: begin
        // process: capture result and flags for the q4 write
        wdata_d     = alu_bus.result;
        res_flags_d = alu_bus.flags_out;
        phase_d     = bdr_pkg::BDR_PH_Q4;
      end
      bdr_pkg::BDR_PH_Q4: begin
        phase_d = bdr_pkg::BDR_PH_IDLE;
        if (idle_cyc_q) begin
          idle_cyc_d = 1'b0;
        end else if (is_ret) begin
          pc_d       = stack_top;
          sp_d       = (sp_q == '0) ? sp_q : sp_q - SP_W'(1);
          idle_cyc_d = 1'b1;
          phase_d    = bdr_pkg::BDR_PH_Q1;
          if (restore) begin
            acc_d   = sh_acc_q;
            flags_d = sh_flags_q;
            bank_d  = sh_bank_q;
          end
          // restore clear: acc, flags, bank and latches hold
        end else if (op_dec != bdr_pkg::BDR_OP_NONE) begin
          flags_d = res_flags_q;
          if (op_dec == bdr_pkg::BDR_OP_DECADJ || !dest_file) begin
            acc_d = wdata_q;
          end
        end
      end
    endcase
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q     <= bdr_pkg::BDR_PH_IDLE;
      idle_cyc_q  <= 1'b0;
      instr_q     <= '0;
      acc_q       <= '0;
      flags_q     <= '0;
      bank_q      <= '0;
      sh_acc_q    <= '0;
      sh_flags_q  <= '0;
      sh_bank_q   <= '0;
      idx_base_q  <= '0;
      faddr_q     <= '0;
      pc_q        <= '0;
      pcl_up_q    <= '0;
      pcl_hi_q    <= '0;
      wdata_q     <= '0;
      res_flags_q <= '0;
      ext_en_q    <= 1'b0;
      sp_q        <= '0;
      ack_q       <= 1'b0;
      rdata_q     <= '0;
    end else begin
      phase_q     <= phase_d;
      idle_cyc_q  <= idle_cyc_d;
      instr_q     <= instr_d;
      acc_q       <= acc_d;
      flags_q     <= flags_d;
      bank_q      <= bank_d;
      sh_acc_q    <= sh_acc_d;
      sh_flags_q  <= sh_flags_d;
      sh_bank_q   <= sh_bank_d;
      idx_base_q  <= idx_base_d;
      faddr_q     <= faddr_d;
      pc_q        <= pc_d;
      pcl_up_q    <= pcl_up_d;
      pcl_hi_q    <= pcl_hi_d;
      wdata_q     <= wdata_d;
      res_flags_q <= res_flags_d;
      ext_en_q    <= ext_en_d;
      sp_q        <= sp_d;
      ack_q       <= ack_d;
      rdata_q     <= rdata_d;
    end
  end

  // stack storage, written by software pushes only
  always_ff @(posedge clk_i) begin
    if (push_en) begin
      stack_mem[sp_q] <= wb_dat_i[bdr_pkg::PC_W-1:0];
    end
  end

  // outputs
  assign wb_ack_o      = ack_q;
  assign wb_dat_o      = rdata_q;
  assign instr_ready_o = (phase_q == bdr_pkg::BDR_PH_IDLE);
  assign instr_done_o  = (phase_q == bdr_pkg::BDR_PH_Q4)
                         && (idle_cyc_q || !is_ret);
  assign file_addr_o   = faddr_q;
  assign file_rd_o     = (phase_q == bdr_pkg::BDR_PH_Q2) && !idle_cyc_q
                         && (op_dec == bdr_pkg::BDR_OP_DECREMENT_FILE
                             || op_dec == bdr_pkg::BDR_OP_RLC);
  assign file_we_o     = (phase_q == bdr_pkg::BDR_PH_Q4) && !idle_cyc_q
                         && dest_file
                         && (op_dec == bdr_pkg::BDR_OP_DECREMENT_FILE
                             || op_dec == bdr_pkg::BDR_OP_RLC);
  assign file_wdata_o  = wdata_q;
  assign pc_o          = pc_q;
  assign pc_load_o     = (phase_q == bdr_pkg::BDR_PH_Q1) && idle_cyc_q;
endmodule : bdr_exec_unit
`default_nettype wire

// ### bench/bdr_exec_unit_chk.sv
/* port checker for the execution unit: timing of instructions,
   file port use and bus ack. assumes: bound to bdr_exec_unit. */
`default_nettype none
module bdr_exec_unit_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_ack_o,
  input wire logic        instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic        instr_ready_o,
  input wire logic        instr_done_o,
  input wire logic [11:0] file_addr_o,
  input wire logic        file_rd_o,
  input wire logic [7:0]  file_rdata_i,
  input wire logic        file_we_o,
  input wire logic [7:0]  file_wdata_o,
  input wire logic        pc_load_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // decode of the word taken at each edge
  wire logic tk  = instr_valid_i && instr_ready_o;
  wire logic ret = tk && instr_i[15:1] == bdr_pkg::OPC_RET;
  wire logic one = tk && !ret;
  wire logic dec = tk && instr_i[15:10] == bdr_pkg::OPC_DECREMENT_FILE;
  wire logic rlc = tk && instr_i[15:10] == bdr_pkg::OPC_RLC;
  logic [15:0] ins_q;
  // word of the instruction in flight
  always_ff @(posedge clk_i)
    ins_q <= rst_i ? 16'h0000 : (tk ? instr_i : ins_q);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack longer than one cycle");
  property p_one; one |=> !instr_done_o[*3] ##1 instr_done_o; endproperty
  a_one: assert property (p_one) else $error("done not in q4");
  property p_two; ret |=> !instr_ready_o[*7] ##1 instr_done_o; endproperty
  a_two: assert property (p_two) else $error("return not two");
  property p_nop; ret |=> (!file_rd_o && !file_we_o)[*8]; endproperty
  a_nop: assert property (p_nop) else $error("return used file");
  property p_pop; ret |-> ##5 pc_load_o; endproperty
  a_pop: assert property (p_pop) else $error("pc not loaded");
  property p_rd; dec || rlc |-> ##2 file_rd_o; endproperty
  a_rd: assert property (p_rd) else $error("no read in q2");
  property p_dec;
    dec |-> ##4 (!file_we_o || file_wdata_o == 8'($past(file_rdata_i) - 8'h01));
  endproperty
  a_dec: assert property (p_dec) else $error("bad decrement");
  property p_rot;
    rlc |-> ##4 (!file_we_o || file_wdata_o[7:1] == 7'($past(file_rdata_i)));
  endproperty
  a_rot: assert property (p_rot) else $error("bad rotate");
  property p_wr; (dec || rlc) && instr_i[9] |-> ##4 file_we_o; endproperty
  a_wr: assert property (p_wr) else $error("no file write");
  property p_dst; file_we_o |-> ins_q[9] && ins_q[15:10] != 6'h00; endproperty
  a_dst: assert property (p_dst) else $error("stray file write");
  property p_bnk;
    file_rd_o && ins_q[8] |-> file_addr_o[7:0] == ins_q[7:0];
  endproperty
  a_bnk: assert property (p_bnk) else $error("bad banked address");
  property p_hi;
    file_rd_o && !ins_q[8] && ins_q[7] |-> file_addr_o == {4'hF, ins_q[7:0]};
  endproperty
  a_hi: assert property (p_hi) else $error("bad access address");
endmodule : bdr_exec_unit_chk
bind bdr_exec_unit bdr_exec_unit_chk i_bdr_exec_unit_chk (.clk_i, .rst_i,
  .wb_ack_o, .instr_valid_i, .instr_i, .instr_ready_o, .instr_done_o,
  .file_addr_o, .file_rd_o, .file_rdata_i, .file_we_o, .file_wdata_o,
  .pc_load_o);
`default_nettype wire

// ### bench/bdr_exec_unit_tb.sv
/* self-checking bench: reset and bus cases, then table of arithmetic
   rows, then return and mid-run reset cases. assumes: 250 MHz clock, sync reset, one-wait bus. */
`default_nettype none
module bdr_exec_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [15:0] ins;
    logic [7:0]  fd, acc, eacc, ewd;
    logic [4:0]  flg, eflg;
    logic        ext;
    logic [11:0] eadr;
  } bdr_row_s;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, we = 1'h0, iv = 1'h0;
  logic [7:0]  adr = 8'h00, fd = 8'h00, fwd, wd, sw;
  logic [31:0] dat = 32'h0, rdat;
  logic [15:0] ins = 16'h0000;
  logic [11:0] fadr, ad;
  logic [20:0] pc;
  logic        ack, rdy, done, frd, fwe, pcl;
  int mismatches = 0, tests_run = 0, c, ld;
  // ins, fd, acc, eacc, ewd, flg, eflg, ext, eadr
  bdr_row_s rows [12] = '{
    '{16'h0007, 8'h00, 8'hA5, 8'h05, 8'h00, 5'h1C, 5'h1D, 1'h0, 12'h0},
    '{16'h0007, 8'h00, 8'hCE, 8'h34, 8'h00, 5'h00, 5'h01, 1'h0, 12'h0},
    '{16'h0007, 8'h00, 8'h12, 8'h18, 8'h00, 5'h02, 5'h02, 1'h0, 12'h0},
    '{16'h0007, 8'h00, 8'h12, 8'h72, 8'h00, 5'h01, 5'h01, 1'h0, 12'h0},
    '{16'h0610, 8'h01, 8'h33, 8'h33, 8'h00, 5'h00, 5'h07, 1'h0, 12'h010},
    '{16'h0490, 8'h00, 8'h33, 8'hFF, 8'h00, 5'h00, 5'h10, 1'h0, 12'hF90},
    '{16'h0534, 8'h80, 8'h33, 8'h7F, 8'h00, 5'h00, 5'h09, 1'h0, 12'h534},
    '{16'h045F, 8'h01, 8'h33, 8'h00, 8'h00, 5'h00, 5'h07, 1'h1, 12'h25F},
    '{16'h3460, 8'hE6, 8'h33, 8'hCC, 8'h00, 5'h00, 5'h11, 1'h1, 12'h060},
    '{16'h3620, 8'h80, 8'h33, 8'h33, 8'h00, 5'h00, 5'h05, 1'h0, 12'h020},
    '{16'h3401, 8'h41, 8'h33, 8'h83, 8'h00, 5'h01, 5'h10, 1'h0, 12'h001},
    '{16'hFC00, 8'h00, 8'h33, 8'h33, 8'h00, 5'h0A, 5'h0A, 1'h0, 12'h0}};
  bdr_exec_unit i_bdr_exec_unit (.clk_i, .rst_i, .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .instr_valid_i(iv),
    .instr_i(ins), .instr_ready_o(rdy), .instr_done_o(done),
    .file_addr_o(fadr), .file_rd_o(frd), .file_rdata_i(fd),
    .file_we_o(fwe), .file_wdata_o(fwd), .pc_o(pc), .pc_load_o(pcl));
  // 4 ns clock
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // bounded wait ran out
  task automatic lim(input int n);
    if (n >= 20) begin
      mismatches++;
      summarize();
    end
  endtask : lim
  // one classic wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'h1;
    we  <= w;
    adr <= a;
    dat <= d;
    for (n = 0; n < 20 && ack !== 1'h1; n++) @(posedge clk_i);
    lim(n);
    q = rdat;
    cyc <= 1'h0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'h0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  // issue one instruction, log file port and cycle count
  task automatic run(input logic [15:0] i);
    int n;
    @(posedge clk_i);
    ins <= i;
    iv  <= 1'h1;
    for (n = 0; n < 20 && rdy !== 1'h1; n++) @(negedge clk_i);
    lim(n);
    @(posedge clk_i);
    iv <= 1'h0;
    {sw, wd, ad, ld} = {8'h00, 8'hXX, 12'hXXX, 32'h0};
    for (c = 1; c < 20; c++) begin
      @(negedge clk_i);
      if (frd) ad = fadr;
      if (fwe) {sw, wd} = {8'h01, fwd};
      if (pcl) ld = c;
      if (done === 1'h1) break;
    end
    lim(c);
  endtask : run
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(bdr_pkg::ADR_ACC, 32'h0);
    rd(bdr_pkg::ADR_PC, 32'h0);
    rd(8'hFC, 32'h0);
    wr(8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC, 32'h0);
    wr(bdr_pkg::ADR_BANK, 32'h5);
    wr(bdr_pkg::ADR_IDX_BASE, 32'h200);
    // table rows: preset, run, read back
    foreach (rows[k]) begin
      wr(bdr_pkg::ADR_CTRL, {31'h0, rows[k].ext});
      wr(bdr_pkg::ADR_ACC, rows[k].acc);
      wr(bdr_pkg::ADR_FLAGS, rows[k].flg);
      fd <= rows[k].fd;
      run(rows[k].ins);
      chk(c, 4);
      rd(bdr_pkg::ADR_ACC, rows[k].eacc);
      rd(bdr_pkg::ADR_FLAGS, rows[k].eflg);
      if (rows[k].ins[15:10] inside {bdr_pkg::OPC_DECREMENT_FILE, bdr_pkg::OPC_RLC})
        chk(ad, rows[k].eadr);
      chk(sw, rows[k].ins[9]);
      if (rows[k].ins[9]) chk(wd, rows[k].ewd);
    end
    // return with and without shadow restore
    wr(bdr_pkg::ADR_STACK, 32'h1234);
    wr(bdr_pkg::ADR_STACK, 32'h0ABC);
    wr(bdr_pkg::ADR_SH_ACC, 32'h5A);
    wr(bdr_pkg::ADR_SH_FLAGS, 32'h15);
    wr(bdr_pkg::ADR_SH_BANK, 32'h9);
    wr(bdr_pkg::ADR_PCL_UPPER, 32'h3);
    wr(bdr_pkg::ADR_PCL_HIGH, 32'h7);
    run(16'h0013);
    chk(c, 8);
    chk(ld, 5);
    chk(pc, 21'h0ABC);
    rd(bdr_pkg::ADR_ACC, 32'h5A);
    rd(bdr_pkg::ADR_FLAGS, 32'h15);
    rd(bdr_pkg::ADR_BANK, 32'h9);
    rd(bdr_pkg::ADR_PCL_UPPER, 32'h3);
    rd(bdr_pkg::ADR_PCL_HIGH, 32'h7);
    wr(bdr_pkg::ADR_ACC, 32'h22);
    wr(bdr_pkg::ADR_FLAGS, 32'h0A);
    wr(bdr_pkg::ADR_BANK, 32'h2);
    run(16'h0012);
    chk(pc, 21'h1234);
    rd(bdr_pkg::ADR_ACC, 32'h22);
    rd(bdr_pkg::ADR_FLAGS, 32'h0A);
    rd(bdr_pkg::ADR_BANK, 32'h2);
    // mid-run reset empties the stack and clears the accumulator
    wr(bdr_pkg::ADR_STACK, 32'h0777);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(bdr_pkg::ADR_STATE, 32'h0);
    rd(bdr_pkg::ADR_STACK, 32'h0);
    rd(bdr_pkg::ADR_ACC, 32'h0);
    summarize();
  end
endmodule : bdr_exec_unit_tb
`default_nettype wire
